// *** core/ltc_pkg.sv ***
// package for the lite timebase capture timer: offsets, fields, timing
package ltc_pkg;
	// register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CSR = 4'h0;
	localparam logic [3:0] ADDR_CAPTURE = 4'h4;
	localparam logic [3:0] ADDR_RELOAD = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
	localparam logic [1:0] ADDR_HI_MAIN = 2'h0;
	localparam logic [1:0] ADDR_HI_IRQ = 2'h1;
	// control/status field positions
	localparam int CSR_CAPTURE_FLAG = 6;
	localparam int CSR_PERIOD_SEL = 5;
	localparam int CSR_TB_IRQ_EN = 4;
	localparam int CSR_TB_FLAG = 3;
	// interrupt status / mask bit positions
	localparam int IRQ_TIMEBASE = 0;
	localparam int IRQ_CAPTURE = 1;
	localparam int IRQ_RELOAD = 2;
	localparam int IRQ_BITS = 3;
	localparam logic [7:0] CAPTURE_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int OSC_MHZ = 8;
	localparam int TB_SHORT_OSC = 8000;
	localparam int TB_LONG_OSC = 16000;
	localparam int STEP_NS = 4000;
	localparam int CLK_NS = 10;
	localparam int STEP_CYCLES = STEP_NS / CLK_NS;
	// clock cycles per oscillator period, rounded down
	localparam int CLK_PER_OSC = CLK_MHZ / OSC_MHZ;
	localparam int TB_SHORT_CYCLES = TB_SHORT_OSC * CLK_MHZ / OSC_MHZ;
	localparam int TB_LONG_CYCLES = TB_LONG_OSC * CLK_MHZ / OSC_MHZ;
	localparam int TB_COUNT_STEPS = 256;
endpackage

// *** core/ltc_prescaler.sv ***
// free-running prescaler giving one-cycle tick pulses
`timescale 1ns/100ps
module ltc_prescaler #(
	parameter int DIV = 400
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	output logic tick_o
);
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		cnt_d = cnt_q + 24'h000001;
		tick_d = 1'b0;
		if (restart_i)
		begin
			cnt_d = 24'h000000;
		end
		else if (cnt_q >= 24'(DIV - 1))
		begin
			cnt_d = 24'h000000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 24'h000000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
endmodule

// *** core/ltc_timer.sv ***
// top of the lite timebase capture timer with its wishbone slave
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - capture flag bit 6 set on capture, cleared by capture read, writes ignored
// - period select: 0 gives 8000, 1 gives 16000 oscillator periods
// - timebase interrupt enable bit 4 gates timebase_irq_o but not irq_o, software owned
// - timebase flag bit 3 set on overflow, cleared by status read
// - while capture flag clear, any capture pin edge copies counter
// - capture register is read only and zero after reset
// - second counter autoreloads, period 4 us steps up to 1.024 ms
// - maskable capture interrupt, also drives a halt wake-up output
module ltc_timer #(
	parameter int TB_SHORT = ltc_pkg::TB_SHORT_CYCLES,
	parameter int TB_LONG = ltc_pkg::TB_LONG_CYCLES,
	parameter int STEP = ltc_pkg::STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [1:0] wb_adr_hi_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic capture_input_pin_i,
	output logic timebase_irq_o,
	output logic capture_irq_o,
	output logic wakeup_o,
	output logic irq_o
);
	localparam int TB_STEP = TB_SHORT / ltc_pkg::TB_COUNT_STEPS;

	// timebase: a prescaler ticks the 8-bit upcounter; long period halves the tick rate
	logic tb_tick;
	logic tb_half_q;
	logic tb_half_d;
	logic [7:0] tb_cnt_q;
	logic [7:0] tb_cnt_d;
	logic tb_ovf;
	logic period_sel_q;
	logic period_sel_d;

	ltc_prescaler #(
		.DIV(TB_STEP)
	) u_tb_pre (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(1'b0),
		.tick_o(tb_tick)
	);

	// second counter: one count per 4 us step, reloads from software value
	logic ar_tick;
	logic [7:0] ar_cnt_q;
	logic [7:0] ar_cnt_d;
	logic [7:0] reload_q;
	logic [7:0] reload_d;
	logic ar_ovf;

	ltc_prescaler #(
		.DIV(STEP)
	) u_ar_pre (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(1'b0),
		.tick_o(ar_tick)
	);

	always_comb
	begin
		tb_half_d = tb_half_q;
		tb_cnt_d = tb_cnt_q;
		tb_ovf = 1'b0;
		if (tb_tick)
		begin
			// long period counts every second tick
			tb_half_d = period_sel_q ? ~tb_half_q : 1'b0;
			if (!period_sel_q || tb_half_q)
			begin
				tb_cnt_d = tb_cnt_q + 8'h01;
				tb_ovf = (tb_cnt_q == 8'hFF);
			end
		end
		ar_cnt_d = ar_cnt_q;
		ar_ovf = 1'b0;
		if (ar_tick)
		begin
			// autoreload: period is (256 - reload) steps of 4 us
			if (ar_cnt_q == 8'hFF)
			begin
				ar_cnt_d = reload_q;
				ar_ovf = 1'b1;
			end
			else
			begin
				ar_cnt_d = ar_cnt_q + 8'h01;
			end
		end
	end

	// capture pin passes two flops, edge detected behind them
	logic cap_s1_q;
	logic cap_s2_q;
	logic cap_s3_q;
	logic cap_edge;
	assign cap_edge = cap_s2_q ^ cap_s3_q;

	// registers and bus
	logic cap_flag_q;
	logic cap_flag_d;
	logic [7:0] capture_q;
	logic [7:0] capture_d;
	logic tb_flag_q;
	logic tb_flag_d;
	logic tb_ie_q;
	logic tb_ie_d;
	logic [ltc_pkg::IRQ_BITS-1:0] irq_stat_q;
	logic [ltc_pkg::IRQ_BITS-1:0] irq_stat_d;
	logic [ltc_pkg::IRQ_BITS-1:0] irq_mask_q;
	logic [ltc_pkg::IRQ_BITS-1:0] irq_mask_d;
	logic [ltc_pkg::IRQ_BITS-1:0] irq_ev;
	logic ack_q;
	logic ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic tb_irq_q;
	logic cap_irq_q;
	logic wake_q;
	logic irq_q;
	logic req;
	logic rd;
	logic wr;
	logic [7:0] csr_view;

	function automatic logic hit(input logic [1:0] hi, input logic [3:0] lo,
		input logic [1:0] hi_ref, input logic [3:0] lo_ref);
		hit = (hi == hi_ref) && (lo == lo_ref);
	endfunction

	// single access per request: ack drops the cycle after it rises
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign rd = req && !wb_we_i;
	assign wr = req && wb_we_i && wb_sel_i[0];

	always_comb
	begin
		csr_view = 8'h00;
		csr_view[ltc_pkg::CSR_CAPTURE_FLAG] = cap_flag_q;
		csr_view[ltc_pkg::CSR_PERIOD_SEL] = period_sel_q;
		csr_view[ltc_pkg::CSR_TB_IRQ_EN] = tb_ie_q;
		csr_view[ltc_pkg::CSR_TB_FLAG] = tb_flag_q; // bits 2..0 stay zero
	end

	always_comb
	begin
		ack_d = req;
		rdat_d = 32'h00000000;
		period_sel_d = period_sel_q;
		tb_ie_d = tb_ie_q;
		reload_d = reload_q;
		irq_mask_d = irq_mask_q;
		cap_flag_d = cap_flag_q;
		capture_d = capture_q;
		tb_flag_d = tb_flag_q;
		irq_ev = '0;
		irq_ev[ltc_pkg::IRQ_TIMEBASE] = tb_ovf;
		irq_ev[ltc_pkg::IRQ_CAPTURE] = cap_edge && !cap_flag_q;
		irq_ev[ltc_pkg::IRQ_RELOAD] = ar_ovf;
		irq_stat_d = irq_stat_q;
		if (rd)
		begin
			if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_CSR))
			begin
				rdat_d = {24'h000000, csr_view};
				tb_flag_d = 1'b0; // status read clears
			end
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_CAPTURE))
			begin
				rdat_d = {24'h000000, capture_q};
				cap_flag_d = 1'b0; // capture read clears
			end
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_RELOAD))
				rdat_d = {24'h000000, reload_q};
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_IRQ_STATUS))
				rdat_d = {29'h00000000, irq_stat_q};
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_IRQ, ltc_pkg::ADDR_IRQ_MASK))
				rdat_d = {29'h00000000, irq_mask_q};
		end
		if (wr)
		begin
			// CSR flags are not writable; of the CSR only the select and enable bits take data
			if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_CSR))
			begin
				period_sel_d = wb_dat_i[ltc_pkg::CSR_PERIOD_SEL];
				tb_ie_d = wb_dat_i[ltc_pkg::CSR_TB_IRQ_EN];
			end
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_RELOAD))
				reload_d = wb_dat_i[7:0];
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_MAIN, ltc_pkg::ADDR_IRQ_STATUS))
				irq_stat_d = irq_stat_q & ~wb_dat_i[ltc_pkg::IRQ_BITS-1:0];
			else if (hit(wb_adr_hi_i, wb_adr_i, ltc_pkg::ADDR_HI_IRQ, ltc_pkg::ADDR_IRQ_MASK))
				irq_mask_d = wb_dat_i[ltc_pkg::IRQ_BITS-1:0];
		end
		// hardware set wins over any clear in the same cycle
		irq_stat_d = irq_stat_d | irq_ev;
		if (tb_ovf)
			tb_flag_d = 1'b1;
		if (cap_edge && !cap_flag_q)
		begin
			capture_d = tb_cnt_q; // only while flag clear
			cap_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
			tb_half_q <= 1'b0;
			tb_cnt_q <= 8'h00;
			ar_cnt_q <= ltc_pkg::RELOAD_RESET;
			reload_q <= ltc_pkg::RELOAD_RESET;
			period_sel_q <= 1'b0;
			tb_ie_q <= 1'b0;
			tb_flag_q <= 1'b0;
			cap_flag_q <= 1'b0;
			capture_q <= ltc_pkg::CAPTURE_RESET;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
			tb_irq_q <= 1'b0;
			cap_irq_q <= 1'b0;
			wake_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			cap_s1_q <= capture_input_pin_i;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			tb_half_q <= tb_half_d;
			tb_cnt_q <= tb_cnt_d;
			ar_cnt_q <= ar_cnt_d;
			reload_q <= reload_d;
			period_sel_q <= period_sel_d;
			tb_ie_q <= tb_ie_d;
			tb_flag_q <= tb_flag_d;
			cap_flag_q <= cap_flag_d;
			capture_q <= capture_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			tb_irq_q <= tb_flag_d && tb_ie_d;
			cap_irq_q <= (irq_stat_d[ltc_pkg::IRQ_CAPTURE]
				&& irq_mask_d[ltc_pkg::IRQ_CAPTURE]);
			wake_q <= cap_flag_d && irq_mask_d[ltc_pkg::IRQ_CAPTURE];
			irq_q <= |(irq_stat_d & irq_mask_d);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign timebase_irq_o = tb_irq_q;
	assign capture_irq_o = cap_irq_q;
	assign wakeup_o = wake_q;
	assign irq_o = irq_q;
endmodule

// *** testbench/ltc_timer_sva.sv ***
// port checker for the timebase capture timer
`timescale 1ns/100ps
module ltc_timer_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [1:0] wb_adr_hi_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic capture_input_pin_i,
	input wire logic timebase_irq_o,
	input wire logic capture_irq_o,
	input wire logic wakeup_o,
	input wire logic irq_o
);
	logic req;
	logic rd;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = req && !wb_we_i && wb_adr_hi_i == 2'h0;
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
	a_write_zero: assert property (req && wb_we_i |=> wb_dat_o == 32'h0) else $error("write data");
	a_rsvd_zero: assert property (rd && wb_adr_i == 4'h0 |=> wb_dat_o[2:0] == 3'h0)
		else $error("reserved set");
	// a recent pin edge may set the flag again
	a_cap_clear: assert property (rd && wb_adr_i == 4'h4
		&& capture_input_pin_i == $past(capture_input_pin_i, 8) |-> ##[1:3] !wakeup_o)
		else $error("capture flag kept");
	a_tb_clear: assert property (rd && wb_adr_i == 4'h0 |-> ##[1:3] !timebase_irq_o)
		else $error("timebase flag kept");
	// a mask write raises wake in the same cycle as its ack, with no pin edge behind it
	a_wake_cause: assert property ($rose(wakeup_o) && !wb_ack_o
		|-> $past(capture_input_pin_i) != $past(capture_input_pin_i, 8)) else $error("no edge");
	a_irq_or: assert property (capture_irq_o |-> irq_o) else $error("irq low");
	c_wake: cover property (wakeup_o);
	c_tb: cover property (timebase_irq_o);
	c_irq: cover property (irq_o && !capture_irq_o);
endmodule

// *** testbench/ltc_pin_model.sv ***
// capture pin source: toggles the pin lag cycles after a request
`timescale 1ns/100ps
module ltc_pin_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] lag_i,
	output logic pin_o
);
	logic [3:0] cnt = 4'h0;
	initial pin_o = 1'b0;
	always @(posedge clk_i)
	begin
		if (go_i)
			cnt <= lag_i;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (!go_i && cnt == 4'h1)
			pin_o <= ~pin_o;
	end
endmodule

// *** testbench/ltc_timer_tb.sv ***
// bench for the timebase capture timer
`timescale 1ns/100ps
module ltc_timer_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, pin, tbi, capi, wake, irq;
	logic go = 1'b0;
	logic [3:0] lag = 4'h1;
	int n_fail = 0;
	int num_checks = 0;
	int n;
	always #5 clk_i = ~clk_i;
	// short counts keep the run to a few thousand cycles
	ltc_timer #(.TB_SHORT(512), .TB_LONG(1024), .STEP(4)) ltc_timer_i (.clk_i, .rst_i,
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr[3:0]),
		.wb_adr_hi_i(adr[5:4]), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
		.wb_ack_o(ack), .capture_input_pin_i(pin), .timebase_irq_o(tbi),
		.capture_irq_o(capi), .wakeup_o(wake), .irq_o(irq));
	ltc_pin_model ltc_pin_model_i (.clk_i, .go_i(go), .lag_i(lag), .pin_o(pin));
	task final_report();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] v, input logic [31:0] e);
		num_checks++;
		if (v !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", s, e, v);
		end
	endtask
	// a wait that runs out counts as a mismatch
	task tick();
		@(posedge clk_i);
		n++;
		if (n > 3000)
		begin
			n_fail++;
			final_report();
		end
	endtask
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do
			tick();
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask
	task rd(input logic [5:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	// settle first so a level just cleared is not taken as new
	task wait_hi(input logic s);
		repeat (2) @(posedge clk_i);
		n = 0;
		while ((s ? irq : tbi) !== 1'b1)
			tick();
	endtask
	task pe(input logic [3:0] l);
		@(posedge clk_i);
		lag <= l;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (24) @(posedge clk_i);
	endtask
	task t_reset();
		rd(6'h04);
		chk("capture", q, 32'h0);
		wb(1'b1, 6'h04, 32'hFF);
		rd(6'h04);
		chk("capture ro", q, 32'h0);
		rd(6'h14);
		chk("unmapped", q, 32'h0);
		$display("reset test done");
	endtask
	task t_capture();
		logic [31:0] a;
		wb(1'b1, 6'h10, 32'h2);
		pe(4'h1);
		chk("raised", {wake, capi, irq}, 32'h7);
		wb(1'b1, 6'h00, 32'h0);
		rd(6'h00);
		chk("flag kept", q[6], 32'h1);
		pe(4'h9);
		rd(6'h04);
		a = q;
		rd(6'h00);
		chk("flag clear", {q[6], wake}, 32'h0);
		pe(4'h3);
		rd(6'h04);
		chk("recapture", q !== a, 32'h1);
		wb(1'b1, 6'h0C, 32'h2);
		wb(1'b1, 6'h10, 32'h0);
		pe(4'h1);
		chk("masked", {wake, capi, irq}, 32'h0);
		$display("capture test done");
	endtask
	task t_timebase(input logic s);
		wb(1'b1, 6'h00, s ? 32'h30 : 32'h10);
		rd(6'h00);
		chk("select", q[5:4], {s, 1'b1});
		wait_hi(1'b0);
		rd(6'h00);
		wait_hi(1'b0);
		chk("period", n > (s ? 1014 : 502) && n <= (s ? 1024 : 512), 32'h1);
		$display("timebase test done");
	endtask
	task t_reload(input logic [7:0] r);
		wb(1'b1, 6'h00, 32'h0);
		wb(1'b1, 6'h10, 32'h4);
		wb(1'b1, 6'h08, {24'h0, r});
		wb(1'b1, 6'h0C, 32'h7);
		wait_hi(1'b1);
		wb(1'b1, 6'h0C, 32'h4);
		wait_hi(1'b1);
		chk("reload", n > (256 - r) * 4 - 10 && n <= (256 - r) * 4, 32'h1);
		chk("tb off", tbi, 32'h0);
		$display("reload test done");
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_capture();
		t_timebase(1'b0);
		t_timebase(1'b1);
		t_reload(8'hFC);
		t_reload(8'h00);
		final_report();
	end
endmodule
bind ltc_timer ltc_timer_sva ltc_timer_sva_i (.*);
